// *** core/fc_flash_ctrl.v ***
// Host-side flash command controller: APB slave with own registers, drives flash pins.
// Assumes flash pins synchronous to pclk and one operation at a time.
//
// Our own choices: the register offsets and register access over APB.
`default_nettype none
`include "fc_flash_consts.vh"

module fc_flash_ctrl #(
  parameter ADDR_W = 22,
  parameter WP_CYC = (`FC_T_WP_NS + `FC_CLK_NS - 1) / `FC_CLK_NS,
  parameter WPH_CYC = (`FC_T_WPH_NS + `FC_CLK_NS - 1) / `FC_CLK_NS,
  parameter ACC_CYC = (`FC_T_ACC_NS + `FC_CLK_NS - 1) / `FC_CLK_NS,
  parameter RP_CYC = (`FC_T_RP_NS + `FC_CLK_NS - 1) / `FC_CLK_NS,
  parameter RH_CYC = (`FC_T_RH_NS + `FC_CLK_NS - 1) / `FC_CLK_NS
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Flash pins
  output reg [ADDR_W-1:0] flash_addr,
  output reg [15:0] flash_dq_out,
  output reg flash_dq_oe,
  input wire [15:0] flash_dq_in,
  output reg flash_ce_n,
  output reg flash_we_n,
  output reg flash_oe_n,
  output reg flash_reset_n
);

  localparam S_IDLE = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_STROBE = 3'h2;
  localparam S_HOLD = 3'h3;
  localparam S_NEXT = 3'h4;
  localparam S_RST = 3'h5;
  localparam S_RSTH = 3'h6;

  ////////////////////////////////////////////////////////////////////////////////
  // Command step table: {kind, addr12, data8}
  function [22:0] fc_step;
    input [4:0] op;
    input [2:0] idx;
    reg [2:0] k;
    reg [11:0] a;
    reg [7:0] d;
    reg six;
    begin
      k = `FC_K_END;
      a = `FC_A_ANY;
      d = 8'h00;
      six = (op == `FC_OP_CHIP_ERASE) || (op == `FC_OP_SECT_ERASE) ||
            (op == `FC_OP_SP_ENTER) || (op == `FC_OP_LOCKDOWN);
      case (op)
        `FC_OP_READ: if (idx == 3'h0) k = `FC_K_USR_RD;
        `FC_OP_SP_WRITE: if (idx == 3'h0) k = `FC_K_USR_WR0;
        `FC_OP_SUSPEND: if (idx == 3'h0) begin
          k = `FC_K_FIX_WR;
          d = `FC_D_SUSPEND;
        end
        `FC_OP_RESUME: if (idx == 3'h0) begin
          k = `FC_K_FIX_WR;
          d = `FC_D_RESUME;
        end
        `FC_OP_EXIT_SHORT: if (idx == 3'h0) begin
          k = `FC_K_FIX_WR;
          d = `FC_D_EXIT;
        end
        `FC_OP_QUERY: if (idx == 3'h0) begin
          k = `FC_K_FIX_WR;
          a = `FC_A_QUERY;
          d = `FC_D_QUERY;
        end
        `FC_OP_POLL: begin
          if (idx <= `FC_POLL_LAST_RD) k = `FC_K_USR_RD;
          else if (idx == `FC_POLL_EXIT) begin
            k = `FC_K_FIX_WR;
            d = `FC_D_EXIT;
          end
        end
        default: begin
          case (idx)
            3'h0: begin
              k = `FC_K_FIX_WR;
              a = `FC_A_UNLOCK1;
              d = `FC_D_UNLOCK1;
            end
            3'h1: begin
              k = `FC_K_FIX_WR;
              a = `FC_A_UNLOCK2;
              d = `FC_D_UNLOCK2;
            end
            3'h2: begin
              k = `FC_K_FIX_WR;
              a = `FC_A_UNLOCK1;
              case (op)
                `FC_OP_WORD_PROG: d = `FC_D_PROG;
                `FC_OP_DUAL_PROG: d = `FC_D_DUAL;
                `FC_OP_ID_ENTRY: d = `FC_D_ID;
                `FC_OP_PROT_STAT: d = `FC_D_ID;
                `FC_OP_ID_EXIT: d = `FC_D_EXIT;
                `FC_OP_PROT_PROG: d = `FC_D_PROT;
                `FC_OP_PROT_LOCK: d = `FC_D_PROT;
                `FC_OP_SET_CFG: d = `FC_D_CFG;
                default: d = `FC_D_ERASE;
              endcase
            end
            3'h3: begin
              case (op)
                `FC_OP_WORD_PROG: k = `FC_K_USR_WR0;
                `FC_OP_DUAL_PROG: k = `FC_K_USR_WR0;
                `FC_OP_PROT_PROG: k = `FC_K_USR_WR0;
                `FC_OP_SET_CFG: k = `FC_K_USR_WR0;
                `FC_OP_PROT_LOCK: begin
                  k = `FC_K_FIX_WR;
                  a = `FC_A_PROT_LOCK;
                  d = `FC_D_LOCK_BLK;
                end
                `FC_OP_PROT_STAT: begin
                  k = `FC_K_FIX_RD;
                  a = `FC_A_PROT_LOCK;
                end
                default: if (six) begin
                  k = `FC_K_FIX_WR;
                  a = `FC_A_UNLOCK1;
                  d = `FC_D_UNLOCK1;
                end
              endcase
            end
            3'h4: begin
              if (op == `FC_OP_DUAL_PROG) k = `FC_K_USR_WR1;
              else if (six) begin
                k = `FC_K_FIX_WR;
                a = `FC_A_UNLOCK2;
                d = `FC_D_UNLOCK2;
              end
            end
            3'h5: begin
              case (op)
                `FC_OP_CHIP_ERASE: begin
                  k = `FC_K_FIX_WR;
                  a = `FC_A_UNLOCK1;
                  d = `FC_D_CHIP;
                end
                `FC_OP_SECT_ERASE: begin
                  k = `FC_K_USR_ADDR;
                  d = `FC_D_SECTOR;
                end
                `FC_OP_SP_ENTER: begin
                  k = `FC_K_FIX_WR;
                  a = `FC_A_UNLOCK1;
                  d = `FC_D_PROG;
                end
                `FC_OP_LOCKDOWN: begin
                  k = `FC_K_USR_ADDR;
                  d = `FC_D_LOCKDOWN;
                end
                default: k = `FC_K_END;
              endcase
            end
            default: k = `FC_K_END;
          endcase
        end
      endcase
      fc_step = {k, a, d};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers
  reg [4:0] op_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg [31:0] data_reg;
  reg [15:0] rd_reg;
  reg [15:0] prev_reg;
  reg busy_reg;
  reg done_reg;
  reg fail_reg;
  reg failbit_reg;
  reg vlow_reg;
  reg [2:0] state_reg;
  reg [2:0] idx_reg;
  reg [7:0] cnt_reg;

  wire acc = psel && penable && pready;
  wire go = acc && pwrite && (paddr == `FC_REG_CTRL) && pwdata[`FC_CTRL_GO] && !busy_reg;
  wire mapped = (paddr == `FC_REG_CTRL) || (paddr == `FC_REG_ADDR) ||
                (paddr == `FC_REG_DATA) || (paddr == `FC_REG_STAT);
  wire [22:0] step = fc_step(op_reg, idx_reg);
  wire [2:0] step_k = step[22:20];
  wire step_rd = (step_k == `FC_K_USR_RD) || (step_k == `FC_K_FIX_RD);
  wire [15:0] dq_now = flash_dq_in;
  wire toggled = dq_now[`FC_DQ_TOGGLE] ^ prev_reg[`FC_DQ_TOGGLE];
  wire errbits = dq_now[`FC_DQ_FAIL] | dq_now[`FC_DQ_VLOW];

  // APB slave, one wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      op_reg <= `FC_OP_READ;
      addr_reg <= {ADDR_W{1'b0}};
      data_reg <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && !pready) begin
        case (paddr)
          `FC_REG_CTRL: prdata <= {27'h000_0000, op_reg};
          `FC_REG_ADDR: prdata <= {{(32-ADDR_W){1'b0}}, addr_reg};
          `FC_REG_DATA: prdata <= data_reg;
          `FC_REG_STAT: prdata <= {rd_reg, 11'h000, vlow_reg, failbit_reg, fail_reg,
                                   done_reg, busy_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
      if (acc && pwrite && !busy_reg) begin
        if (paddr == `FC_REG_CTRL) op_reg <= pwdata[4:0];
        if (paddr == `FC_REG_ADDR) addr_reg <= pwdata[ADDR_W-1:0];
        if (paddr == `FC_REG_DATA) data_reg <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flash bus sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      idx_reg <= 3'h0;
      cnt_reg <= 8'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      failbit_reg <= 1'b0;
      vlow_reg <= 1'b0;
      rd_reg <= 16'h0000;
      prev_reg <= 16'h0000;
      flash_addr <= {ADDR_W{1'b0}};
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_reset_n <= 1'b1;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (go) begin
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            failbit_reg <= 1'b0;
            vlow_reg <= 1'b0;
            idx_reg <= 3'h0;
            cnt_reg <= 8'h00;
            if (pwdata[4:0] == `FC_OP_HW_RESET) begin
              flash_reset_n <= 1'b0;
              state_reg <= S_RST;
            end else begin
              state_reg <= S_NEXT;
            end
          end
        end
        S_NEXT: begin
          if (step_k == `FC_K_END) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= S_IDLE;
          end else begin
            // Only low byte and A11..A0 matter for fixed cycles
            case (step_k)
              `FC_K_USR_WR0, `FC_K_USR_RD: flash_addr <= addr_reg;
              `FC_K_USR_WR1: flash_addr <= addr_reg ^ {{(ADDR_W-1){1'b0}}, 1'b1};
              `FC_K_USR_ADDR: flash_addr <= addr_reg;
              default: flash_addr <= {{(ADDR_W-12){1'b0}}, step[19:8]};
            endcase
            case (step_k)
              `FC_K_USR_WR0: flash_dq_out <= data_reg[15:0];
              `FC_K_USR_WR1: flash_dq_out <= data_reg[31:16];
              default: flash_dq_out <= {8'h00, step[7:0]};
            endcase
            flash_dq_oe <= !step_rd;
            flash_ce_n <= 1'b0;
            cnt_reg <= 8'h00;
            state_reg <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (step_rd) flash_oe_n <= 1'b0;
          else flash_we_n <= 1'b0;
          state_reg <= S_STROBE;
        end
        S_STROBE: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg + 8'h01 >= (step_rd ? ACC_CYC[7:0] : WP_CYC[7:0])) begin
            cnt_reg <= 8'h00;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            state_reg <= S_HOLD;
            if (step_rd) begin
              rd_reg <= dq_now;
              if (op_reg == `FC_OP_POLL) begin
                failbit_reg <= dq_now[`FC_DQ_FAIL];
                vlow_reg <= dq_now[`FC_DQ_VLOW];
                prev_reg <= dq_now;
                // Poll: 0/2 load, 1/3 compare; error bits force a second pair
                if (idx_reg == 3'h1 || idx_reg == `FC_POLL_LAST_RD) begin
                  if (!toggled) idx_reg <= `FC_POLL_EXIT + 3'h1;
                  else if (idx_reg == `FC_POLL_LAST_RD) begin
                    fail_reg <= 1'b1;
                    idx_reg <= `FC_POLL_EXIT;
                  end else if (errbits) idx_reg <= 3'h2;
                  else idx_reg <= 3'h0;
                end else begin
                  idx_reg <= idx_reg + 3'h1;
                end
              end else begin
                idx_reg <= idx_reg + 3'h1;
              end
            end else begin
              idx_reg <= idx_reg + 3'h1;
            end
          end
        end
        S_HOLD: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg + 8'h01 >= WPH_CYC[7:0]) begin
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            state_reg <= S_NEXT;
          end
        end
        S_RST: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg + 8'h01 >= RP_CYC[7:0]) begin
            cnt_reg <= 8'h00;
            flash_reset_n <= 1'b1;
            state_reg <= S_RSTH;
          end
        end
        S_RSTH: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg + 8'h01 >= RH_CYC[7:0]) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule // fc_flash_ctrl
`default_nettype wire

// *** core/fc_flash_consts.vh ***
// Constants for the flash command controller: APB map, flash command codes, timing.
// Assumes a 100 MHz pclk and a 16-bit parallel NOR flash with unlock-prefixed commands.
//
// How it works
// - Dual-word program; second address flips A0
// - Exit cycles always carry F0 data
// - Protection program: C0 prefix, user word
// - Poll in pairs, repeated while toggling; failure bits force two more
// - Recheck toggle even after failure bit seen
// - Polling reads use software-given valid address
// - Query entry single 98 write at 55
`ifndef FC_FLASH_CONSTS_VH
`define FC_FLASH_CONSTS_VH

// APB register offsets
`define FC_REG_CTRL 12'h000
`define FC_REG_ADDR 12'h004
`define FC_REG_DATA 12'h008
`define FC_REG_STAT 12'h00C
`define FC_CTRL_GO 31
`define FC_STAT_BUSY 0
`define FC_STAT_DONE 1
`define FC_STAT_FAIL 2
`define FC_STAT_FAILBIT 3
`define FC_STAT_VLOW 4

// Operation codes in CTRL[4:0]
`define FC_OP_READ 5'h00
`define FC_OP_WORD_PROG 5'h01
`define FC_OP_DUAL_PROG 5'h02
`define FC_OP_CHIP_ERASE 5'h03
`define FC_OP_SECT_ERASE 5'h04
`define FC_OP_SP_ENTER 5'h05
`define FC_OP_SP_WRITE 5'h06
`define FC_OP_LOCKDOWN 5'h07
`define FC_OP_SUSPEND 5'h08
`define FC_OP_RESUME 5'h09
`define FC_OP_ID_ENTRY 5'h0A
`define FC_OP_ID_EXIT 5'h0B
`define FC_OP_EXIT_SHORT 5'h0C
`define FC_OP_PROT_PROG 5'h0D
`define FC_OP_PROT_LOCK 5'h0E
`define FC_OP_PROT_STAT 5'h0F
`define FC_OP_SET_CFG 5'h10
`define FC_OP_QUERY 5'h11
`define FC_OP_POLL 5'h12
`define FC_OP_HW_RESET 5'h13

// Step kinds
`define FC_K_END 3'h0
`define FC_K_FIX_WR 3'h1
`define FC_K_USR_WR0 3'h2
`define FC_K_USR_WR1 3'h3
`define FC_K_USR_RD 3'h4
`define FC_K_USR_ADDR 3'h5
`define FC_K_FIX_RD 3'h6

// Flash command addresses and codes
`define FC_A_UNLOCK1 12'h555
`define FC_A_UNLOCK2 12'hAAA
`define FC_A_QUERY 12'h055
`define FC_A_PROT_LOCK 12'h080
`define FC_A_ANY 12'h000
`define FC_D_UNLOCK1 8'hAA
`define FC_D_UNLOCK2 8'h55
`define FC_D_ERASE 8'h80
`define FC_D_CHIP 8'h10
`define FC_D_SECTOR 8'h30
`define FC_D_PROG 8'hA0
`define FC_D_DUAL 8'hE0
`define FC_D_LOCKDOWN 8'h60
`define FC_D_SUSPEND 8'hB0
`define FC_D_RESUME 8'h30
`define FC_D_ID 8'h90
`define FC_D_EXIT 8'hF0
`define FC_D_PROT 8'hC0
`define FC_D_LOCK_BLK 8'h00
`define FC_D_CFG 8'hD0
`define FC_D_QUERY 8'h98

// Status line positions in the read word
`define FC_DQ_TOGGLE 6
`define FC_DQ_FAIL 5
`define FC_DQ_VLOW 3

// Poll step indices
`define FC_POLL_LAST_RD 3'h3
`define FC_POLL_EXIT 3'h4

// Timing
`define FC_CLK_NS 10
`define FC_T_WP_NS 35
`define FC_T_WPH_NS 20
`define FC_T_ACC_NS 70
`define FC_T_RP_NS 500
`define FC_T_RH_NS 50

`endif

// *** testbench/fc_flash_ctrl_sva.sv ***
// Checker for the flash controller: APB handshake and flash strobe timing.
// Assumes the controller's default timing parameters; bound below.
`default_nettype none
module fc_flash_ctrl_sva #(
  parameter int ACC_CYC = 7
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Flash pins
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_ERR_RDY: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr without pready");
  AST_WE_LOW: assert property ($fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n)
    else $error("write pulse width");
  AST_WE_HOLD: assert property ($rose(flash_we_n) |-> !flash_ce_n [*2] ##1 flash_ce_n)
    else $error("write hold");
  AST_WE_CE: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe && flash_oe_n)
    else $error("write strobe outside select");
  AST_STABLE: assert property (!flash_ce_n && !$past(flash_ce_n)
    |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("pins moved in cycle");
  AST_RD_TIME: assert property ($fell(flash_oe_n) |-> ##ACC_CYC $rose(flash_oe_n))
    else $error("read access length");
  COV_WR: cover property ($rose(flash_we_n));
  COV_RD: cover property ($rose(flash_oe_n));
  COV_ERR: cover property (pslverr);
endmodule // fc_flash_ctrl_sva
bind fc_flash_ctrl fc_flash_ctrl_sva #(.ACC_CYC(ACC_CYC)) i_fc_flash_ctrl_sva (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n,
  .flash_we_n, .flash_oe_n);
`default_nettype wire

// *** testbench/fc_flash_model.sv ***
// Behavioural flash device: decodes command writes, reports status on reads.
// Assumes strobes synchronous to clk; array data is a fixed address pattern.
`default_nettype none
module fc_flash_model #(
  parameter logic [15:0] MAKER = 16'h00C5, // Arbitrary value
  parameter logic [15:0] DEVC = 16'h0D17 // Arbitrary value
) (
  // Flash pins
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [21:0] addr,
  input wire logic [15:0] dq_wr,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  output logic [15:0] dq_rd,
  // Bench control and view
  input wire logic fail_mode,
  output logic [15:0] wr_cnt,
  output logic [21:0] last_a,
  output logic [15:0] last_d,
  output logic hi_bad,
  output logic idm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [47:0] hist;
  logic [7:0] tgt;
  logic [1:0] busy;
  logic we_q, oe_q, tog, sp;
  logic [15:0] last_rd;
  wire logic [7:0] d = dq_wr[7:0];
  wire logic [15:0] stat = {8'h00, ~tgt[7], tog, fail_mode, 3'b001, 2'b00};
  wire logic [15:0] arr = addr[15:0] ^ 16'h3C3C;
  wire logic [15:0] val = (busy != 2'h0) ? stat : !idm ? arr :
    (addr == 22'h000000) ? MAKER : (addr == 22'h000001) ? DEVC : arr;
  // Released bus shows the inverse of the last value
  assign dq_rd = oe_n ? ~last_rd : val;
  //////////////////////////////
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {hist, tgt, busy, tog, sp, last_rd, idm, hi_bad, wr_cnt, last_a, last_d} <= '0;
      // Strobe history starts at idle level: no false edge after reset
      we_q <= 1'b1;
      oe_q <= 1'b1;
    end else begin
      we_q <= we_n;
      oe_q <= oe_n;
      if (oe_n && !oe_q) begin
        last_rd <= val;
        tog <= ~tog;
        if (busy != 2'h0 && !fail_mode) busy <= busy - 2'h1;
      end
      if (!ce_n && we_n && !we_q) begin
        wr_cnt <= wr_cnt + 16'h0001;
        last_a <= addr;
        last_d <= dq_wr;
        hist <= {hist[39:0], d};
        if ((addr[11:0] == 12'h555 || addr[10:0] == 11'h2AA) && dq_wr[15:8] != 8'h00)
          hi_bad <= 1'b1;
        if (sp || hist[23:0] == 24'hAA55A0) begin
          tgt <= d;
          busy <= 2'h3;
        end
        if (hist[39:0] == 40'hAA5580AA55 && (d == 8'h30 || d == 8'h10)) begin
          tgt <= 8'hFF;
          busy <= 2'h3;
        end
        if (hist[39:0] == 40'hAA5580AA55 && d == 8'hA0) sp <= 1'b1;
        if (hist[15:0] == 16'hAA55 && d == 8'h90) idm <= 1'b1;
        if (d == 8'hF0 || (idm && hist[15:0] == 16'hAA55 && d != 8'h90)) begin
          idm <= 1'b0;
          busy <= 2'h0;
        end
      end
    end
  end
endmodule // fc_flash_model
`default_nettype wire

// *** testbench/tb.sv ***
// Testbench for the flash controller: APB tasks run operations against a flash model.
// Assumes the controller's default timing parameters.
`default_nettype none
`include "fc_flash_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic fail_mode = 1'b0, pready, pslverr, rerr, dq_oe, ce_n, we_n, oe_n, rst_n, hi_bad, idm;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat, stat;
  logic [21:0] faddr, last_a;
  logic [15:0] dq_out, dq_in, last_d, wr_cnt, cnt0;
  int fail_count = 0, total_checks = 0, cyc = 0;
  localparam logic [15:0] MAKER = 16'h00C5; // Arbitrary value
  localparam logic [15:0] DEVC = 16'h0D17; // Arbitrary value
  logic [4:0] ops [17] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08, 5'h09, 5'h0A,
    5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h10, 5'h11, 5'h06, 5'h0F};
  int cnts [17] = '{4, 5, 6, 6, 6, 6, 1, 1, 3, 3, 1, 4, 4, 4, 1, 1, 3};
  logic [15:0] dats [17] = '{16'h0001, 16'hBEEF, 16'h0010, 16'h0030, 16'h00A0, 16'h0060,
    16'h00B0, 16'h0030, 16'h0090, 16'h00F0, 16'h00F0, 16'h0001, 16'h0000, 16'h0001, 16'h0098,
    16'h0001, 16'h0090};
  fc_flash_ctrl i_fc_flash_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
    .flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_reset_n(rst_n));
  fc_flash_model #(.MAKER(MAKER), .DEVC(DEVC)) i_fc_flash_model (.clk(pclk),
    .rst_n(rst_n & presetn), .addr(faddr), .dq_wr(dq_out), .ce_n, .we_n, .oe_n, .dq_rd(dq_in),
    .fail_mode, .wr_cnt, .last_a, .last_d, .hi_bad, .idm);
  always #5 pclk = ~pclk;
  //////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run(input logic [4:0] op);
    int n = 0;
    apb(1'b1, `FC_REG_CTRL, {1'b1, 26'h0, op});
    do begin
      apb(1'b0, `FC_REG_STAT, 32'h0);
      n++;
    end while (rdat[1] !== 1'b1 && n < 400);
    chk("op done", rdat[1], 1'b1);
    stat = rdat;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      summarize();
    end
  end
  //////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `FC_REG_STAT, 32'h0);
    chk("stat reset", rdat, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {rerr, rdat[30:0]}, 32'h80000000);
    apb(1'b1, `FC_REG_ADDR, 32'h000ABCD5);
    apb(1'b1, `FC_REG_DATA, 32'hBEEF0001);
    for (int i = 0; i < 17; i++) begin
      cnt0 = wr_cnt;
      run(ops[i]);
      chk("write count", wr_cnt - cnt0, cnts[i]);
      chk("last data", last_d, dats[i]);
      if (ops[i] == 5'h02) chk("pair addr", last_a, 22'h0ABCD4);
    end
    chk("upper byte", hi_bad, 1'b0);
    chk("prot stat id", idm, 1'b1);
    run(5'h13);
    chk("reset id", idm, 1'b0);
    chk("reset count", wr_cnt, 16'h0000);
    run(5'h01);
    run(5'h12);
    chk("poll ok", {stat[31:16], 13'h0, stat[2:0]}, 32'h80E90002);
    fail_mode <= 1'b1;
    run(5'h01);
    run(5'h12);
    chk("poll fail", stat[4:0], 5'h0E);
    chk("exit data", last_d, 16'h00F0);
    fail_mode <= 1'b0;
    run(5'h0A);
    chk("id mode", idm, 1'b1);
    for (int a = 0; a < 2; a++) begin
      apb(1'b1, `FC_REG_ADDR, a);
      run(5'h00);
      chk("id word", stat[31:16], a ? DEVC : MAKER);
    end
    run(5'h0C);
    chk("id exit", idm, 1'b0);
    run(5'h00);
    chk("array", stat[31:16], 16'h3C3D);
    summarize();
  end
endmodule // tb
`default_nettype wire
